// ==== test/mptl_monitor.sv ====
// Port checker for the motor protection trip logic
`timescale 1ns/1ps
`default_nettype none
module mptl_monitor #(parameter NRELAY = 6) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [15:0] phase_cur_i,
    input wire logic [7:0] imb_pct_i,
    input wire logic [7:0] therm_pct_i,
    input wire logic ovl_trip_i,
    input wire logic [NRELAY-1:0] relay_o,
    input wire logic sc_ind_o,
    input wire logic imb_ind_o,
    input wire logic ovl_ind_o,
    input wire logic config_fault_indicator_o,
    input wire logic ext_fault_o,
    input wire logic gear1_o,
    input wire logic gear2_o,
    input wire logic [1:0] ctl_inv_o
);
    localparam logic [7:0] OVL_THR = 8'h46;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence gears_off; !gear1_o && !gear2_o; endsequence
    AST_GEAR_EXCL: assert property (!(gear1_o && gear2_o))
        else $error("both gears on");
    AST_CFG_RELAY: assert property (config_fault_indicator_o
        && $past(config_fault_indicator_o) |-> relay_o == '0)
        else $error("relay on with bad map");
    AST_INV_RUN: assert property (ctl_inv_o[0] == !(gear1_o || gear2_o))
        else $error("running output polarity");
    AST_OVL_SET: assert property (ovl_trip_i |-> ##2 ovl_ind_o)
        else $error("overload not indicated");
    AST_OVL_CLR: assert property ($fell(ovl_ind_o)
        |-> $past(therm_pct_i, 2) <= OVL_THR)
        else $error("overload cleared while hot");
    AST_SC_CAUSE: assert property ($rose(sc_ind_o)
        |-> $past(phase_cur_i, 3) != 16'h0000)
        else $error("short circuit without current");
    AST_IMB_CAUSE: assert property ($rose(imb_ind_o)
        |-> $past(imb_pct_i, 3) != 8'h00)
        else $error("imbalance without cause");
    AST_STOP: assert property (ext_fault_o |-> ##1 gears_off)
        else $error("gear on during fault");
endmodule // mptl_monitor
`default_nettype wire

// ==== test/mptl_partner.sv ====
// Contactor and discrete input model
`timescale 1ns/1ps
`default_nettype none
module mptl_partner #(parameter ACK_DLY = 4) (
    input  wire logic       sys_clk_i,
    input  wire logic       gear1_i,
    input  wire logic       stop_press_i,
    input  wire logic       g2_req_i,
    output wire logic [7:0] din_o
);
    logic [ACK_DLY-1:0] pipe_r = '0;
    // Contactor closes a few cycles after its coil
    always @(posedge sys_clk_i) pipe_r <= {pipe_r[ACK_DLY-2:0], gear1_i};
    // Stop loop carries voltage while healthy
    // Gear two request from the outside controller on input 4
    assign din_o = {3'h0, g2_req_i, 1'b0, pipe_r[ACK_DLY-1],
                    !stop_press_i, 1'b0};
endmodule // mptl_partner
`default_nettype wire

// ==== test/mptl_top_tb_top.sv ====
// Directed testbench for the motor protection trip logic
`timescale 1ns/1ps
`default_nettype none
module mptl_top_tb_top;
    logic sys_clk_i = 1'b0, rst_n_i = 1'b0, ovl_trip_i = 1'b0;
    logic stop_press = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic g2_req = 1'b0;
    logic [15:0] phase_cur_i = '0;
    logic [7:0] imb_pct_i = '0, therm_pct_i = '0, reg_addr_i = '0;
    logic [31:0] reg_wdata_i = '0;
    wire [7:0] din_i;
    wire [31:0] reg_rdata_o;
    wire [5:0] relay_o;
    wire [1:0] ctl_inv_o;
    wire sc_ind_o, imb_ind_o, ovl_ind_o, config_fault_indicator_o;
    wire ext_fault_o, gear1_o, gear2_o;
    int err_total = 0, n_compared = 0;
    mptl_top #(.SC_TICK_CYC(24'd20), .IMB_TICK_CYC(24'd40)) mptl_top_i (
        .sys_clk_i, .rst_n_i, .phase_cur_i, .imb_pct_i, .therm_pct_i,
        .ovl_trip_i, .din_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .relay_o, .sc_ind_o, .imb_ind_o,
        .ovl_ind_o, .config_fault_indicator_o, .ext_fault_o, .gear1_o,
        .gear2_o, .ctl_inv_o);
    mptl_partner mptl_partner_i (.sys_clk_i, .gear1_i(gear1_o),
        .stop_press_i(stop_press), .g2_req_i(g2_req), .din_o(din_i));
    initial forever #4 sys_clk_i = ~sys_clk_i;
    task automatic chk(input string n, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge sys_clk_i);
        chk("rdata", e, reg_rdata_o);
    endtask
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge sys_clk_i);
        err_total++;
        conclude;
    end
    initial begin
        repeat (4) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        wt(2);
        chk("relay", 6'h01, relay_o);
        chk("inv", 2'b11, ctl_inv_o);
        rd(8'h04, 32'h64);
        rd(8'h40, 32'h0);
        wr(8'h0C, 32'h2);
        @(posedge sys_clk_i) phase_cur_i <= 16'd1300;
        wt(90);
        chk("sc", 1, sc_ind_o);
        @(posedge sys_clk_i) phase_cur_i <= 16'h0;
        wt(25);
        chk("sc", 0, sc_ind_o);
        wr(8'h1C, 32'h1);
        wt(3);
        chk("cfg", 1, config_fault_indicator_o);
        rd(8'h1C, 32'h2);
        wr(8'h1C, 32'hA);
        wt(3);
        chk("relay", 6'h03, relay_o);
        @(posedge sys_clk_i) phase_cur_i <= 16'd1300;
        wt(90);
        chk("relay", 6'h01, relay_o);
        @(posedge sys_clk_i) phase_cur_i <= 16'h0;
        wt(25);
        chk("sc", 1, sc_ind_o);
        wr(8'h00, 32'h1);
        wt(3);
        chk("sc", 0, sc_ind_o);
        wr(8'h08, 32'h0);
        @(posedge sys_clk_i) phase_cur_i <= 16'hFFFF;
        wt(90);
        chk("sc", 0, sc_ind_o);
        @(posedge sys_clk_i) phase_cur_i <= 16'h0;
        wr(8'h14, 32'h1);
        @(posedge sys_clk_i) imb_pct_i <= 8'd60;
        wt(130);
        chk("imb", 1, imb_ind_o);
        @(posedge sys_clk_i) imb_pct_i <= 8'd0;
        wt(45);
        chk("imb", 0, imb_ind_o);
        wr(8'h00, 32'h2);
        @(posedge sys_clk_i) therm_pct_i <= 8'd90;
        ovl_trip_i <= 1'b1;
        @(posedge sys_clk_i) ovl_trip_i <= 1'b0;
        wt(3);
        chk("relay", 6'h02, relay_o);
        @(posedge sys_clk_i) therm_pct_i <= 8'd60;
        wt(3);
        chk("ovl", 0, ovl_ind_o);
        wr(8'h20, 32'h2351);
        wr(8'h28, 32'h20003);
        wr(8'h00, 32'h31E);
        wt(6);
        chk("gears", 2'b01, {gear2_o, gear1_o});
        wt(300);
        chk("gears", 2'b10, {gear2_o, gear1_o});
        @(posedge sys_clk_i) stop_press <= 1'b1;
        wt(4);
        chk("ext", 1, ext_fault_o);
        @(posedge sys_clk_i) stop_press <= 1'b0;
        wt(4);
        chk("ext", 1, ext_fault_o);
        wr(8'h00, 32'h1);
        wt(3);
        chk("ext", 0, ext_fault_o);
        wr(8'h20, 32'h92351);
        wr(8'h00, 32'h248);
        @(posedge sys_clk_i) g2_req <= 1'b1;
        wt(4);
        chk("ext", 1, ext_fault_o);
        chk("gears", 2'b00, {gear2_o, gear1_o});
        @(posedge sys_clk_i) g2_req <= 1'b0;
        wr(8'h00, 32'h1);
        wt(3);
        chk("ext", 0, ext_fault_o);
        conclude;
    end
endmodule // mptl_top_tb_top
bind mptl_top mptl_monitor #(.NRELAY(NRELAY)) mptl_monitor_i (.sys_clk_i,
    .rst_n_i, .phase_cur_i, .imb_pct_i, .therm_pct_i, .ovl_trip_i,
    .relay_o, .sc_ind_o, .imb_ind_o, .ovl_ind_o, .config_fault_indicator_o,
    .ext_fault_o, .gear1_o, .gear2_o, .ctl_inv_o);
`default_nettype wire

// ==== verilog/mptl_map.vh ====
// Constants for the motor protection trip logic
`ifndef MPTL_MAP_VH
`define MPTL_MAP_VH

`define MPTL_CLK_MHZ        125
`define MPTL_SC_PERIOD_US   5000
`define MPTL_IMB_PERIOD_US  10000
`define MPTL_SC_TICK_CYC    (`MPTL_SC_PERIOD_US * `MPTL_CLK_MHZ)
`define MPTL_IMB_TICK_CYC   (`MPTL_IMB_PERIOD_US * `MPTL_CLK_MHZ)
`define MPTL_ACK_TMO_TICKS  16'h00C8

`define MPTL_REG_CTRL       8'h00
`define MPTL_REG_RATED      8'h04
`define MPTL_REG_SC_MULT    8'h08
`define MPTL_REG_SC_DELAY   8'h0C
`define MPTL_REG_IMB_THR    8'h10
`define MPTL_REG_IMB_DELAY  8'h14
`define MPTL_REG_OVL_THR    8'h18
`define MPTL_REG_RELAY_MAP  8'h1C
`define MPTL_REG_INPUT_FUNC 8'h20
`define MPTL_REG_GEAR_CFG   8'h24
`define MPTL_REG_GEAR_TIME  8'h28
`define MPTL_REG_STATUS     8'h2C

`define MPTL_CTRL_CLR       0
`define MPTL_CTRL_OVL_AUTO  1
`define MPTL_CTRL_EXT_AUTO  2
`define MPTL_CTRL_TWO_GEAR  3
`define MPTL_CTRL_G1_OFF    4
`define MPTL_CTRL_THR_CHK   5
`define MPTL_CTRL_EXT_G2    6
`define MPTL_CTRL_EXT_VAR   7
`define MPTL_CTRL_ACK_USED  8
`define MPTL_CTRL_START     9

`define MPTL_MAP_SC         0
`define MPTL_MAP_OVL        1
`define MPTL_MAP_IMB        2

`define MPTL_FN_NONE        4'h0
`define MPTL_FN_RESET       4'h1
`define MPTL_FN_START       4'h2
`define MPTL_FN_ACK         4'h3
`define MPTL_FN_MOTOR_TEMP  4'h4
`define MPTL_FN_ESTOP       4'h5
`define MPTL_FN_GROUND      4'h6
`define MPTL_FN_OVER_TEMP   4'h7
`define MPTL_FN_OTHER_FLT   4'h8
`define MPTL_FN_GEAR2       4'h9

`define MPTL_RST_CTRL       10'h000
`define MPTL_RST_RATED      16'h0064
`define MPTL_RST_SC_MULT    8'h0C
`define MPTL_RST_SC_DELAY   16'h0008
`define MPTL_RST_IMB_THR    8'h32
`define MPTL_RST_IMB_DELAY  16'h0190
`define MPTL_RST_OVL_THR    8'h46
`define MPTL_RST_RELAY_MAP  18'h00002
`define MPTL_RST_INPUT_FUNC 32'h00000001
`define MPTL_RST_GEAR_PCT   8'h32
`define MPTL_RST_GEAR_THR   8'h78
`define MPTL_RST_GEAR_DLY   16'h01F4
`define MPTL_RST_GEAR_PAUSE 16'h00C8

`endif

// ==== verilog/mptl_stage_timer.v ====
// Delay counter for one periodically evaluated protection stage
`timescale 1ns/1ps
`default_nettype none

module mptl_stage_timer #(
    parameter CW = 16
) (
    input  wire          sys_clk_i,
    input  wire          rst_n_i,
    input  wire          tick_i,
    input  wire          arm_i,
    input  wire          exceed_i,
    input  wire [CW-1:0] delay_i,
    output reg           trip_o
);

    reg [CW-1:0] cnt_r;

    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cnt_r  <= {CW{1'b0}};
            trip_o <= 1'b0;
        end else if (!arm_i) begin
            cnt_r  <= {CW{1'b0}};
            trip_o <= 1'b0;
        end else if (tick_i) begin
            if (exceed_i) begin
                // Trips one period after delay reached
                if (cnt_r >= delay_i) begin
                    trip_o <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
                end
            end else begin
                cnt_r  <= {CW{1'b0}};
                trip_o <= 1'b0;
            end
        end
    end

endmodule // mptl_stage_timer

`default_nettype wire

// ==== verilog/mptl_top.v ====
// Motor protection trip logic: stages, relay mapping, gear sequencing
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "mptl_map.vh"

module mptl_top #(
    parameter [23:0] SC_TICK_CYC  = `MPTL_SC_TICK_CYC,
    parameter [23:0] IMB_TICK_CYC = `MPTL_IMB_TICK_CYC,
    parameter        NRELAY       = 6,
    parameter        NIN          = 8
) (
    input  wire             sys_clk_i,
    input  wire             rst_n_i,
    input  wire [15:0]      phase_cur_i,
    input  wire [7:0]       imb_pct_i,
    input  wire [7:0]       therm_pct_i,
    input  wire             ovl_trip_i,
    input  wire [NIN-1:0]   din_i,
    input  wire [7:0]       reg_addr_i,
    input  wire [31:0]      reg_wdata_i,
    input  wire             reg_wr_i,
    input  wire             reg_rd_i,
    output reg  [31:0]      reg_rdata_o,
    output reg  [NRELAY-1:0] relay_o,
    output reg              sc_ind_o,
    output reg              imb_ind_o,
    output reg              ovl_ind_o,
    output reg              config_fault_indicator_o,
    output reg              ext_fault_o,
    output reg              gear1_o,
    output reg              gear2_o,
    output reg  [1:0]       ctl_inv_o
);

    localparam MW = 3 * NRELAY;
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_G1    = 3'h1;
    localparam [2:0] ST_DLY   = 3'h2;
    localparam [2:0] ST_PAUSE = 3'h3;
    localparam [2:0] ST_G2    = 3'h4;
    localparam [2:0] ST_ERR   = 3'h5;

    reg [9:0]     ctrl_r;
    reg [15:0]    rated_r;
    reg [7:0]     sc_mult_r;
    reg [15:0]    sc_delay_r;
    reg [7:0]     imb_thr_r;
    reg [15:0]    imb_delay_r;
    reg [7:0]     ovl_thr_r;
    reg [MW-1:0]  relay_map_r;
    reg [31:0]    in_func_r;
    reg [7:0]     gear_pct_r;
    reg [7:0]     gear_thr_r;
    reg [15:0]    gear_dly_r;
    reg [15:0]    gear_pause_r;
    reg           map_bad_r;
    reg [23:0]    sc_div_r;
    reg [23:0]    imb_div_r;
    reg           sc_tick_r;
    reg           imb_tick_r;
    reg           sc_lat_r;
    reg           imb_lat_r;
    reg           ovl_lat_r;
    reg           ext_flt_r;
    reg           safety_r;
    reg           ack_err_r;
    reg           gear_err_r;
    reg [2:0]     state_r;
    reg [15:0]    gcnt_r;
    reg           g1_r;
    reg           g2_r;

    wire wr_ctrl  = reg_wr_i && (reg_addr_i == `MPTL_REG_CTRL);
    wire clr_wr   = wr_ctrl && reg_wdata_i[`MPTL_CTRL_CLR];
    wire ovl_auto = ctrl_r[`MPTL_CTRL_OVL_AUTO];
    wire ext_auto = ctrl_r[`MPTL_CTRL_EXT_AUTO];
    wire two_gear = ctrl_r[`MPTL_CTRL_TWO_GEAR];
    wire g1_off   = ctrl_r[`MPTL_CTRL_G1_OFF];
    wire thr_chk  = ctrl_r[`MPTL_CTRL_THR_CHK];
    wire ext_g2   = ctrl_r[`MPTL_CTRL_EXT_G2];
    wire ext_var  = ctrl_r[`MPTL_CTRL_EXT_VAR];
    wire ack_used = ctrl_r[`MPTL_CTRL_ACK_USED];

    // Input function decode and polarity
    reg [15:0] fn_act;
    reg [15:0] fn_seen;
    reg [3:0]  fn;
    reg        low_act;
    integer    i;
    always @* begin
        fn_act  = 16'h0000;
        fn_seen = 16'h0000;
        fn      = 4'h0;
        low_act = 1'b0;
        for (i = 0; i < NIN; i = i + 1) begin
            fn = in_func_r[4*i +: 4];
            low_act = (fn == `MPTL_FN_MOTOR_TEMP) ||
                      (fn == `MPTL_FN_ESTOP) ||
                      (fn == `MPTL_FN_GROUND) ||
                      (fn == `MPTL_FN_OVER_TEMP) ||
                      (fn == `MPTL_FN_OTHER_FLT);
            fn_seen[fn] = 1'b1;
            fn_act[fn]  = fn_act[fn] |
                          (low_act ? ~din_i[i] : din_i[i]);
        end
    end

    wire in_bad = !fn_seen[`MPTL_FN_RESET] ||
                  (ack_used && !(fn_seen[`MPTL_FN_START] &&
                                 fn_seen[`MPTL_FN_ACK]));
    wire clr = clr_wr || fn_act[`MPTL_FN_RESET];
    wire ext_in = fn_act[`MPTL_FN_MOTOR_TEMP] | fn_act[`MPTL_FN_GROUND] |
                  fn_act[`MPTL_FN_OVER_TEMP] | fn_act[`MPTL_FN_OTHER_FLT];

    // Effective relay map, overload pinned in extended variant
    reg [MW-1:0] eff_map;
    integer      n;
    always @* begin
        eff_map = relay_map_r;
        for (n = 0; n < NRELAY; n = n + 1) begin
            if (ext_var) begin
                eff_map[3*n+`MPTL_MAP_OVL] = (n == 0);
            end
        end
    end

    reg sc_asg;
    reg imb_asg;
    integer k;
    always @* begin
        sc_asg  = 1'b0;
        imb_asg = 1'b0;
        for (k = 0; k < NRELAY; k = k + 1) begin
            sc_asg  = sc_asg  | eff_map[3*k+`MPTL_MAP_SC];
            imb_asg = imb_asg | eff_map[3*k+`MPTL_MAP_IMB];
        end
    end

    // Overload must appear somewhere in a written map unless the extended variant is set
    reg wmap_ovl;
    integer m;
    always @* begin
        wmap_ovl = 1'b0;
        for (m = 0; m < NRELAY; m = m + 1) begin
            wmap_ovl = wmap_ovl | reg_wdata_i[3*m+`MPTL_MAP_OVL];
        end
    end

    // Thresholds, scaled to avoid division
    wire in_g1   = two_gear && (state_r != ST_G2);
    wire [7:0] scale = in_g1 ? gear_pct_r : 8'h64;
    wire [39:0] cur_x100 = {24'h000000, phase_cur_i} * 40'h64;
    wire [39:0] sc_lim = {24'h000000, rated_r} * {32'h0, scale} *
                         {32'h0, sc_mult_r};
    wire sc_arm    = (sc_mult_r != 8'h00);
    wire sc_exceed = sc_arm && (cur_x100 > sc_lim);
    wire imb_arm    = (imb_thr_r != 8'h00);
    wire imb_exceed = imb_arm && (imb_pct_i > imb_thr_r);
    wire [39:0] cur_x10k = {24'h000000, phase_cur_i} * 40'h2710;
    wire [39:0] g2_lim = {24'h000000, rated_r} * {32'h0, gear_pct_r} *
                         {32'h0, gear_thr_r};
    wire cur_ok = !thr_chk || (cur_x10k <= g2_lim);

    // Detection period enables
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            sc_div_r   <= 24'h000000;
            imb_div_r  <= 24'h000000;
            sc_tick_r  <= 1'b0;
            imb_tick_r <= 1'b0;
        end else begin
            sc_tick_r  <= (sc_div_r == SC_TICK_CYC - 24'h1);
            imb_tick_r <= (imb_div_r == IMB_TICK_CYC - 24'h1);
            sc_div_r   <= (sc_div_r == SC_TICK_CYC - 24'h1) ?
                          24'h000000 : sc_div_r + 24'h1;
            imb_div_r  <= (imb_div_r == IMB_TICK_CYC - 24'h1) ?
                          24'h000000 : imb_div_r + 24'h1;
        end
    end

    wire sc_raw;
    wire imb_raw;

    mptl_stage_timer #(.CW(16)) u_sc_timer (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .tick_i    (sc_tick_r),
        .arm_i     (sc_arm),
        .exceed_i  (sc_exceed),
        .delay_i   (sc_delay_r),
        .trip_o    (sc_raw)
    );

    mptl_stage_timer #(.CW(16)) u_imb_timer (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .tick_i    (imb_tick_r),
        .arm_i     (imb_arm),
        .exceed_i  (imb_exceed),
        .delay_i   (imb_delay_r),
        .trip_o    (imb_raw)
    );

    // Trip latches; a new set always beats a clear
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            sc_lat_r  <= 1'b0;
            imb_lat_r <= 1'b0;
            ovl_lat_r <= 1'b0;
            ext_flt_r <= 1'b0;
            safety_r  <= 1'b0;
        end else begin
            if (sc_raw) begin
                sc_lat_r <= 1'b1;
            end else if (sc_asg ? clr : !sc_exceed) begin
                sc_lat_r <= 1'b0;
            end
            if (imb_raw) begin
                imb_lat_r <= 1'b1;
            end else if (imb_asg ? clr : !imb_exceed) begin
                imb_lat_r <= 1'b0;
            end
            // No enable term on the overload stage
            if (ovl_trip_i) begin
                ovl_lat_r <= 1'b1;
            end else if ((ovl_auto || clr) &&
                         (therm_pct_i <= ovl_thr_r)) begin
                ovl_lat_r <= 1'b0;
            end
            if (ext_in) begin
                ext_flt_r <= 1'b1;
            end else if (ext_auto || clr) begin
                ext_flt_r <= 1'b0;
            end
            if (fn_act[`MPTL_FN_ESTOP]) begin
                safety_r <= 1'b1;
            end else if (clr) begin
                safety_r <= 1'b0;
            end
        end
    end

    wire run_req = ctrl_r[`MPTL_CTRL_START] || fn_act[`MPTL_FN_START];
    wire stop = !run_req || sc_lat_r || imb_lat_r || ovl_lat_r ||
                ext_flt_r || safety_r || ack_err_r ||
                config_fault_indicator_o;
    wire dly_done = (gcnt_r >= gear_dly_r);

    // Gear sequencer, counts in 10 ms periods
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state_r    <= ST_IDLE;
            gcnt_r     <= 16'h0000;
            g1_r       <= 1'b0;
            g2_r       <= 1'b0;
            ack_err_r  <= 1'b0;
            gear_err_r <= 1'b0;
        end else begin
            if (clr && !(state_r == ST_ERR && !gear_err_r)) begin
                ack_err_r <= 1'b0;
            end
            case (state_r)
            ST_IDLE: begin
                g1_r   <= 1'b0;
                g2_r   <= 1'b0;
                gcnt_r <= 16'h0000;
                if (run_req && !stop) begin
                    g1_r    <= 1'b1;
                    state_r <= ST_G1;
                end
            end
            ST_G1: begin
                if (stop) begin
                    state_r <= ST_IDLE;
                end else if (!two_gear) begin
                    gcnt_r <= 16'h0000;
                end else if (ack_used && !fn_act[`MPTL_FN_ACK]) begin
                    if (imb_tick_r) begin
                        gcnt_r <= gcnt_r + 16'h1;
                    end
                    if (gcnt_r >= `MPTL_ACK_TMO_TICKS) begin
                        ack_err_r <= 1'b1;
                        state_r   <= ST_IDLE;
                    end
                end else begin
                    gcnt_r  <= 16'h0000;
                    state_r <= ST_DLY;
                end
            end
            ST_DLY: begin
                if (imb_tick_r && !dly_done) begin
                    gcnt_r <= gcnt_r + 16'h1;
                end
                if (stop) begin
                    state_r <= ST_IDLE;
                end else if (ext_g2 && fn_act[`MPTL_FN_GEAR2] &&
                             !(dly_done && cur_ok)) begin
                    gear_err_r <= 1'b1;
                    g1_r       <= 1'b0;
                    state_r    <= ST_ERR;
                end else if (dly_done && cur_ok &&
                             (!ext_g2 || fn_act[`MPTL_FN_GEAR2])) begin
                    g1_r   <= 1'b0;
                    gcnt_r <= 16'h0000;
                    if (g1_off) begin
                        state_r <= ST_PAUSE;
                    end else begin
                        g2_r    <= 1'b1;
                        state_r <= ST_G2;
                    end
                end
            end
            ST_PAUSE: begin
                if (imb_tick_r) begin
                    gcnt_r <= gcnt_r + 16'h1;
                end
                if (stop) begin
                    state_r <= ST_IDLE;
                end else if (gcnt_r >= gear_pause_r) begin
                    g2_r    <= 1'b1;
                    state_r <= ST_G2;
                end
            end
            ST_G2: begin
                if (stop) begin
                    state_r <= ST_IDLE;
                end
            end
            ST_ERR: begin
                g1_r <= 1'b0;
                g2_r <= 1'b0;
                if (clr) begin
                    gear_err_r <= 1'b0;
                    state_r    <= ST_IDLE;
                end
            end
            default: begin
                state_r <= ST_IDLE;
            end
            endcase
            // Stop drops both gear coils at once
            if (stop) begin
                g1_r <= 1'b0;
                g2_r <= 1'b0;
            end
        end
    end

    // Relay drive
    wire [2:0] trips = {imb_lat_r, ovl_lat_r, sc_lat_r};
    reg [NRELAY-1:0] relay_nxt;
    integer r;
    always @* begin
        relay_nxt = {NRELAY{1'b0}};
        for (r = 0; r < NRELAY; r = r + 1) begin
            relay_nxt[r] = (|eff_map[3*r +: 3]) &&
                           !(|(eff_map[3*r +: 3] & trips)) &&
                           !config_fault_indicator_o;
        end
    end

    // Register writes and outputs
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ctrl_r       <= `MPTL_RST_CTRL;
            rated_r      <= `MPTL_RST_RATED;
            sc_mult_r    <= `MPTL_RST_SC_MULT;
            sc_delay_r   <= `MPTL_RST_SC_DELAY;
            imb_thr_r    <= `MPTL_RST_IMB_THR;
            imb_delay_r  <= `MPTL_RST_IMB_DELAY;
            ovl_thr_r    <= `MPTL_RST_OVL_THR;
            relay_map_r  <= `MPTL_RST_RELAY_MAP;
            in_func_r    <= `MPTL_RST_INPUT_FUNC;
            gear_pct_r   <= `MPTL_RST_GEAR_PCT;
            gear_thr_r   <= `MPTL_RST_GEAR_THR;
            gear_dly_r   <= `MPTL_RST_GEAR_DLY;
            gear_pause_r <= `MPTL_RST_GEAR_PAUSE;
            map_bad_r    <= 1'b0;
            reg_rdata_o  <= 32'h00000000;
            relay_o      <= {NRELAY{1'b0}};
            sc_ind_o     <= 1'b0;
            imb_ind_o    <= 1'b0;
            ovl_ind_o    <= 1'b0;
            config_fault_indicator_o <= 1'b0;
            ext_fault_o  <= 1'b0;
            gear1_o      <= 1'b0;
            gear2_o      <= 1'b0;
            ctl_inv_o    <= 2'h3;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= {reg_wdata_i[9:1], 1'b0};
            end
            if (reg_wr_i) begin
                case (reg_addr_i)
                `MPTL_REG_RATED:     rated_r     <= reg_wdata_i[15:0];
                `MPTL_REG_SC_MULT:   sc_mult_r   <= reg_wdata_i[7:0];
                `MPTL_REG_SC_DELAY:  sc_delay_r  <= reg_wdata_i[15:0];
                `MPTL_REG_IMB_THR:   imb_thr_r   <= reg_wdata_i[7:0];
                `MPTL_REG_IMB_DELAY: imb_delay_r <= reg_wdata_i[15:0];
                `MPTL_REG_OVL_THR:   ovl_thr_r   <= reg_wdata_i[7:0];
                `MPTL_REG_RELAY_MAP: begin
                    if (wmap_ovl || ext_var) begin
                        relay_map_r <= reg_wdata_i[MW-1:0];
                        map_bad_r   <= 1'b0;
                    end else begin
                        map_bad_r <= 1'b1;
                    end
                end
                `MPTL_REG_INPUT_FUNC: in_func_r <= reg_wdata_i;
                `MPTL_REG_GEAR_CFG: begin
                    gear_pct_r <= reg_wdata_i[7:0];
                    gear_thr_r <= reg_wdata_i[15:8];
                end
                `MPTL_REG_GEAR_TIME: begin
                    gear_dly_r   <= reg_wdata_i[15:0];
                    gear_pause_r <= reg_wdata_i[31:16];
                end
                default: begin
                end
                endcase
            end
            reg_rdata_o <= 32'h00000000;
            if (reg_rd_i) begin
                case (reg_addr_i)
                `MPTL_REG_CTRL:      reg_rdata_o <= {22'h0, ctrl_r};
                `MPTL_REG_RATED:     reg_rdata_o <= {16'h0, rated_r};
                `MPTL_REG_SC_MULT:   reg_rdata_o <= {24'h0, sc_mult_r};
                `MPTL_REG_SC_DELAY:  reg_rdata_o <= {16'h0, sc_delay_r};
                `MPTL_REG_IMB_THR:   reg_rdata_o <= {24'h0, imb_thr_r};
                `MPTL_REG_IMB_DELAY: reg_rdata_o <= {16'h0, imb_delay_r};
                `MPTL_REG_OVL_THR:   reg_rdata_o <= {24'h0, ovl_thr_r};
                `MPTL_REG_RELAY_MAP: reg_rdata_o <= {{(32-MW){1'b0}}, eff_map};
                `MPTL_REG_INPUT_FUNC: reg_rdata_o <= in_func_r;
                `MPTL_REG_GEAR_CFG:
                    reg_rdata_o <= {16'h0, gear_thr_r, gear_pct_r};
                `MPTL_REG_GEAR_TIME:
                    reg_rdata_o <= {gear_pause_r, gear_dly_r};
                `MPTL_REG_STATUS:
                    reg_rdata_o <= {17'h0, state_r, 1'b0, g2_r, g1_r,
                                    gear_err_r, ack_err_r, safety_r,
                                    ext_flt_r, in_bad, map_bad_r,
                                    ovl_lat_r, imb_lat_r, sc_lat_r};
                default:             reg_rdata_o <= 32'h00000000;
                endcase
            end
            relay_o     <= relay_nxt;
            sc_ind_o    <= sc_lat_r;
            imb_ind_o   <= imb_lat_r;
            ovl_ind_o   <= ovl_lat_r;
            config_fault_indicator_o <= map_bad_r || in_bad;
            ext_fault_o <= ext_flt_r || safety_r || ack_err_r ||
                           gear_err_r;
            gear1_o     <= g1_r;
            gear2_o     <= g2_r;
            ctl_inv_o   <= ~{!stop, g1_r || g2_r};
        end
    end

endmodule // mptl_top

`default_nettype wire
